// File: dprf_pkg.sv
// constants, field layouts and carrier types for the dual-port memory block
// assumes one 100 MHz clock domain
`default_nettype none
package dprf_pkg;
   // geometry: 512 words of 64 data plus 8 check bits
   localparam int MEM_WORDS = 512;
   localparam int WORD_W    = 72;
   localparam int DATA_W    = 64;
   localparam int CHK_W     = 8;
   localparam int ADDR_W    = 16;
   localparam int REG_AW    = 8;
   localparam int LVL_W     = 10;
   localparam logic [LVL_W-1:0] FIFO_DEPTH = 10'h200;

   // port width codes: depth x width of one port entry
   localparam logic [2:0] W_X1  = 3'h0;
   localparam logic [2:0] W_X2  = 3'h1;
   localparam logic [2:0] W_X4  = 3'h2;
   localparam logic [2:0] W_X9  = 3'h3;
   localparam logic [2:0] W_X18 = 3'h4;
   localparam logic [2:0] W_X36 = 3'h5;
   localparam logic [2:0] W_X72 = 3'h6;

   // output policy during a write cycle
   typedef enum logic [1:0] {
      POL_READ_FIRST  = 2'b00,
      POL_WRITE_FIRST = 2'b01,
      POL_NO_CHANGE   = 2'b10
   } dprf_policy_t;

   // register byte addresses
   localparam logic [REG_AW-1:0] REG_CFG_A  = 8'h00;
   localparam logic [REG_AW-1:0] REG_CFG_B  = 8'h04;
   localparam logic [REG_AW-1:0] REG_MODE   = 8'h08;
   localparam logic [REG_AW-1:0] REG_AFULL  = 8'h0C;
   localparam logic [REG_AW-1:0] REG_AEMPTY = 8'h10;
   localparam logic [REG_AW-1:0] REG_STATUS = 8'h14;

   // reset values
   localparam logic [5:0]       CFG_RESET    = 6'h05;
   localparam logic [8:0]       MODE_RESET   = 9'h000;
   localparam logic [LVL_W-1:0] AFULL_RESET  = 10'h1F0;
   localparam logic [LVL_W-1:0] AEMPTY_RESET = 10'h010;

   // per-port configuration: {policy, outreg, width}
   typedef struct packed {
      dprf_policy_t policy;
      logic         outreg;
      logic [2:0]   width;
   } dprf_port_cfg_t;

   // global mode bits, bit 0 is split_read_write_mode
   typedef struct packed {
      logic half_b;
      logic half_a;
      logic ecc_en;
      logic fwft;
      logic fifo_en;
      logic casc_upper;
      logic casc_en;
      logic split;
      logic split_read_write_mode;
   } dprf_mode_t;

   // one port access request, sampled at the clock edge
   typedef struct packed {
      logic              en;
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } dprf_port_req_t;

   // one port read answer
   typedef struct packed {
      logic              sbit;
      logic              dbit;
      logic [WORD_W-1:0] rdata;
   } dprf_port_rsp_t;
endpackage
`default_nettype wire

// File: dprf_mem.sv
// true dual-port 36 Kb memory with fifo controller and sec-ded check logic
// assumes user fabric on the same clock drives both ports and the fifo strobes
//
// Overview of operation
// - all accesses sampled on the port clock edge
// - address clocked; read data held until next
// - optional output register adds one cycle
// - write-cycle output: old, new, or unchanged
// - widths x1 through x72 per port
// - ports use unrelated widths on shared array
// - split into two independent half memories
// - wide ports only in split read/write mode
// - split read/write mode: write side fixed wide
// - two memories cascade into 64K x 1
// - eight check bits; correct single, detect double
// - encoder and decoder usable standalone
// - queue controller advances its own addresses
// - queue flags full, empty, nearly full/empty
// - nearly full/empty thresholds programmable
// - queue write and read widths identical
// - fall-through shows first word before read
// - after each read, fall-through already shows the next word
`timescale 1ns/1ns
`default_nettype none
module dprf_mem
   import dprf_pkg::*;
(
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic [dprf_pkg::REG_AW-1:0] reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [31:0]                reg_rdata,
   input  wire dprf_pkg::dprf_port_req_t   req_a,
   input  wire dprf_pkg::dprf_port_req_t   req_b,
   output dprf_pkg::dprf_port_rsp_t        rsp_a,
   output dprf_pkg::dprf_port_rsp_t        rsp_b,
   input  wire logic                       casc_in_a,
   input  wire logic                       casc_in_b,
   output logic                            casc_out_a,
   output logic                            casc_out_b,
   input  wire logic                       fifo_push,
   input  wire logic [dprf_pkg::WORD_W-1:0] fifo_wdata,
   input  wire logic                       fifo_pop,
   output logic      [dprf_pkg::WORD_W-1:0] fifo_rdata,
   output logic                            fifo_full,
   output logic                            fifo_empty,
   output logic                            fifo_afull,
   output logic                            fifo_aempty,
   input  wire logic [dprf_pkg::DATA_W-1:0] enc_data,
   output logic      [dprf_pkg::CHK_W-1:0] enc_check,
   input  wire logic [dprf_pkg::WORD_W-1:0] dec_word,
   output logic      [dprf_pkg::DATA_W-1:0] dec_data,
   output logic                            dec_sbit,
   output logic                            dec_dbit
);
   import dprf_pkg::*;

   // check bits over hamming positions 1..71; bit 7 is overall parity
   function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
      logic [CHK_W-1:0] c;
      int               k;
      c = '0;
      k = 0;
      for (int p = 1; p < WORD_W; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (d[k])
               c[6:0] = c[6:0] ^ p[6:0];
            k++;
         end
      end
      c[7] = (^d) ^ (^c[6:0]);
      return c;
   endfunction

   // decode: {dbit, sbit, corrected data}
   function automatic logic [DATA_W+1:0] ecc_dec(input logic [WORD_W-1:0] w);
      logic [DATA_W-1:0] d;
      logic [6:0]        syn;
      logic              par;
      int                k;
      d   = w[DATA_W-1:0];
      syn = 7'(ecc_gen(d) ^ {1'b0, w[70:64]});
      par = ^w;
      k   = 0;
      for (int p = 1; p < WORD_W; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (par && syn == p[6:0])
               d[k] = ~d[k];
            k++;
         end
      end
      return {(!par && syn != 7'h00), par, d};
   endfunction

   // port width after mode limits
   function automatic logic [2:0] eff_width(input logic [2:0] w, input int p,
                                            input dprf_mode_t m);
      logic [2:0] lim;
      lim = m.split ? (m.split_read_write_mode ? W_X36 : W_X18)
                    : (m.split_read_write_mode ? W_X72 : W_X36);
      if (m.casc_en)
         return W_X1;
      if (m.split_read_write_mode && p == 1)
         return lim;
      return (w > lim) ? lim : w;
   endfunction

   // word bits owned by one entry
   function automatic logic [WORD_W-1:0] lane_mask(input logic [2:0] m,
                                                   input logic [5:0] lane);
      logic [WORD_W-1:0] r;
      r = '0;
      for (int i = 0; i < DATA_W; i++)
         if ((i >> m) == int'(lane))
            r[i] = 1'b1;
      if (m >= W_X9)
         for (int j = 0; j < CHK_W; j++)
            if ((j >> (m - W_X9)) == int'(lane))
               r[DATA_W+j] = 1'b1;
      return r;
   endfunction

   // copy an entry into every lane
   function automatic logic [WORD_W-1:0] spread(input logic [2:0] m,
                                                input logic [WORD_W-1:0] d);
      logic [WORD_W-1:0] r;
      r = '0;
      for (int i = 0; i < DATA_W; i++)
         r[i] = d[i & ((1 << m) - 1)];
      if (m >= W_X9)
         for (int j = 0; j < CHK_W; j++)
            r[DATA_W+j] = d[(1 << m) + (j & ((1 << (m - W_X9)) - 1))];
      return r;
   endfunction

   // pull one entry out of a stored word, low aligned
   function automatic logic [WORD_W-1:0] gather(input logic [2:0] m,
                                                input logic [5:0] lane,
                                                input logic [WORD_W-1:0] w);
      logic [WORD_W-1:0] r;
      r = '0;
      for (int i = 0; i < DATA_W; i++)
         if (i < (1 << m))
            r[i] = w[(int'(lane) << m) + i];
      if (m >= W_X9)
         for (int j = 0; j < CHK_W; j++)
            if (j < (1 << (m - W_X9)))
               r[(1 << m) + j] = w[DATA_W + (int'(lane) << (m - W_X9)) + j];
      return r;
   endfunction

   // storage and configuration state
   logic [WORD_W-1:0]    mem [MEM_WORDS];  // shared bit array
   dprf_port_cfg_t       cfg [2];          // per-port config
   dprf_mode_t           mode;             // global mode bits
   logic [LVL_W-1:0]     afull_thr;        // nearly-full threshold
   logic [LVL_W-1:0]     aempty_thr;       // nearly-empty threshold
   dprf_port_req_t       req [2];          // port requests as an array
   logic [WORD_W-1:0]    port_q [2];       // output flops per port
   logic                 sbit_q [2];       // single-error flags
   logic                 dbit_q [2];       // double-error flags
   logic                 cas_q [2];        // cascade bit out per port
   logic [8:0]           word_ix [2];      // word index per port
   logic [WORD_W-1:0]    merged [2];       // word after a write
   logic                 wr_go [2];        // port writes array
   logic [8:0]           wptr;             // fifo write address
   logic [8:0]           rptr;             // fifo read address
   logic [LVL_W-1:0]     cnt;              // words held in the array
   logic                 ovalid;           // fwft output valid
   logic                 push_ok;          // accepted push
   logic                 take;             // array word moved to output
   logic                 consume;          // word handed to the reader
   logic                 next_ovalid;      // next value of ovalid
   logic [LVL_W-1:0]     next_level;       // next occupancy

   assign req[0] = req_a;
   assign req[1] = req_b;

   // per-port datapath over the shared array
   for (genvar g = 0; g < 2; g++)
   begin : g_port
      logic [2:0]        m;          // effective width code
      logic [5:0]        lane;       // entry within the word
      logic [WORD_W-1:0] wd;         // write entry, check bits inserted
      logic [WORD_W-1:0] mask;       // owned bits of the word
      logic [WORD_W-1:0] old_e;      // entry before the write
      logic [WORD_W-1:0] new_e;      // entry after the write
      logic              prot;       // protected 64-bit access
      logic              rd_ok;      // port may present read data
      logic              own;        // cascade half owns the address
      logic [WORD_W-1:0] stage;      // first output stage
      logic [WORD_W-1:0] next_stage; // value loaded into stage
      logic              s_sb;       // stage single-error flag
      logic              s_db;       // stage double-error flag
      logic              next_sb;    // next single-error flag
      logic              next_db;    // next double-error flag
      logic              low_sel;    // cascade read hit the lower memory
      logic [DATA_W+1:0] dec;        // decoder result

      // address decode and write merge
      always_comb
      begin
         int sh;
         sh   = 6 - int'(eff_width(cfg[g].width, g, mode));
         m    = eff_width(cfg[g].width, g, mode);
         lane = 6'((int'(req[g].addr) & ((1 << sh) - 1)));
         word_ix[g] = 9'((int'(req[g].addr) >> sh));
         if (mode.split)
            word_ix[g] = {(g == 0) ? mode.half_a : mode.half_b, word_ix[g][7:0]};
         prot  = mode.ecc_en && m == W_X72;
         wd    = prot ? {ecc_gen(req[g].wdata[DATA_W-1:0]),
                         req[g].wdata[DATA_W-1:0]} : req[g].wdata;
         mask  = lane_mask(m, lane);
         merged[g] = (mem[word_ix[g]] & ~mask) | (spread(m, wd) & mask);
         own   = !mode.casc_en || (req[g].addr[15] == mode.casc_upper);
         rd_ok = !(mode.split_read_write_mode && g == 1);
         wr_go[g] = req[g].en && req[g].we && own && !mode.fifo_en
                    && !(mode.split_read_write_mode && g == 0);
         old_e = gather(m, lane, mem[word_ix[g]]);
         new_e = gather(m, lane, merged[g]);
      end

      // choose what the read path shows this cycle
      always_comb
      begin
         next_stage = stage;
         next_sb    = s_sb;
         next_db    = s_db;
         dec        = ecc_dec(old_e);
         if (req[g].en && rd_ok && !mode.fifo_en)
         begin
            if (!wr_go[g] || cfg[g].policy == POL_READ_FIRST)
            begin
               next_stage = prot ? {old_e[WORD_W-1:DATA_W], dec[DATA_W-1:0]} : old_e;
               next_sb    = prot && dec[DATA_W];
               next_db    = prot && dec[DATA_W+1];
            end
            else if (cfg[g].policy == POL_WRITE_FIRST)
            begin
               next_stage = new_e;
               next_sb    = 1'b0;
               next_db    = 1'b0;
            end
         end
      end

      // stage and output flops; output holds until the next read
      always_ff @(posedge mclk)
      begin
         if (rst)
         begin
            stage     <= '0;
            s_sb      <= 1'b0;
            s_db      <= 1'b0;
            low_sel   <= 1'b0;
            port_q[g] <= '0;
            sbit_q[g] <= 1'b0;
            dbit_q[g] <= 1'b0;
            cas_q[g]  <= 1'b0;
         end
         else
         begin
            stage   <= next_stage;
            s_sb    <= next_sb;
            s_db    <= next_db;
            cas_q[g] <= next_stage[0];
            if (req[g].en)
               low_sel <= mode.casc_en && mode.casc_upper && !req[g].addr[15];
            // cascade forces the second stage so the neighbour bit lines up
            if (mode.casc_en && mode.casc_upper && low_sel)
               port_q[g] <= {{(WORD_W-1){1'b0}}, (g == 0) ? casc_in_a : casc_in_b};
            else if (cfg[g].outreg || mode.casc_en)
               port_q[g] <= stage;
            else
               port_q[g] <= next_stage;
            sbit_q[g] <= (cfg[g].outreg || mode.casc_en) ? s_sb : next_sb;
            dbit_q[g] <= (cfg[g].outreg || mode.casc_en) ? s_db : next_db;
         end
      end
   end

   assign rsp_a      = '{sbit: sbit_q[0], dbit: dbit_q[0], rdata: port_q[0]};
   assign rsp_b      = '{sbit: sbit_q[1], dbit: dbit_q[1], rdata: port_q[1]};
   assign casc_out_a = cas_q[0];
   assign casc_out_b = cas_q[1];

   // array writes; port b lands last and wins a collision
   always_ff @(posedge mclk)
   begin
      for (int p = 0; p < 2; p++)
         if (wr_go[p])
            mem[word_ix[p]] <= merged[p];
      if (push_ok)
         mem[wptr] <= fifo_wdata;
   end

   // fifo handshake terms; one width on both sides
   always_comb
   begin
      logic [LVL_W-1:0] level;
      level   = cnt + {{(LVL_W-1){1'b0}}, mode.fwft && ovalid};
      push_ok = mode.fifo_en && fifo_push && level != FIFO_DEPTH;
      if (mode.fwft)
      begin
         // prefetch while the output is free or draining
         take    = mode.fifo_en && cnt != '0 && (!ovalid || fifo_pop);
         consume = mode.fifo_en && fifo_pop && ovalid;
      end
      else
      begin
         take    = mode.fifo_en && fifo_pop && cnt != '0;
         consume = take;
      end
      next_ovalid = mode.fwft && (take || (ovalid && !consume));
      next_level  = level + {{(LVL_W-1){1'b0}}, push_ok}
                          - {{(LVL_W-1){1'b0}}, consume};
   end

   // fifo addresses and occupancy advance on their own
   always_ff @(posedge mclk)
   begin
      if (rst || !mode.fifo_en)
      begin
         wptr   <= '0;
         rptr   <= '0;
         cnt    <= '0;
         ovalid <= 1'b0;
      end
      else
      begin
         if (push_ok)
            wptr <= wptr + 9'h001;
         if (take)
            rptr <= rptr + 9'h001;
         cnt    <= cnt + {{(LVL_W-1){1'b0}}, push_ok} - {{(LVL_W-1){1'b0}}, take};
         ovalid <= next_ovalid;
      end
   end

   // fifo read data and flags, registered; fwft empty from next_ovalid, other flags from the next occupancy
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         fifo_rdata  <= '0;
         fifo_full   <= 1'b0;
         fifo_empty  <= 1'b1;
         fifo_afull  <= 1'b0;
         fifo_aempty <= 1'b1;
      end
      else
      begin
         if (take)
            fifo_rdata <= mem[rptr];
         fifo_full   <= next_level == FIFO_DEPTH;
         fifo_empty  <= mode.fwft ? !next_ovalid : next_level == '0;
         fifo_afull  <= next_level >= afull_thr;
         fifo_aempty <= next_level <= aempty_thr;
      end
   end

   // standalone check-bit encoder and decoder
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         enc_check <= '0;
         dec_data  <= '0;
         dec_sbit  <= 1'b0;
         dec_dbit  <= 1'b0;
      end
      else
      begin
         enc_check <= ecc_gen(enc_data);
         {dec_dbit, dec_sbit, dec_data} <= ecc_dec(dec_word);
      end
   end

   // configuration register writes
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cfg[0]     <= CFG_RESET;
         cfg[1]     <= CFG_RESET;
         mode       <= MODE_RESET;
         afull_thr  <= AFULL_RESET;
         aempty_thr <= AEMPTY_RESET;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            REG_CFG_A:  cfg[0]     <= reg_wdata[5:0];
            REG_CFG_B:  cfg[1]     <= reg_wdata[5:0];
            REG_MODE:   mode       <= reg_wdata[8:0];
            REG_AFULL:  afull_thr  <= reg_wdata[LVL_W-1:0];
            REG_AEMPTY: aempty_thr <= reg_wdata[LVL_W-1:0];
            default:    ;                                          // unmapped: ignored
         endcase
      end
   end

   // register read data, one cycle after the strobe
   always_ff @(posedge mclk)
   begin
      if (rst || !reg_rd)
         reg_rdata <= '0;
      else
      begin
         unique case (reg_addr)
            REG_CFG_A:  reg_rdata <= {26'h0000000, cfg[0]};
            REG_CFG_B:  reg_rdata <= {26'h0000000, cfg[1]};
            REG_MODE:   reg_rdata <= {23'h000000, mode};
            REG_AFULL:  reg_rdata <= {22'h000000, afull_thr};
            REG_AEMPTY: reg_rdata <= {22'h000000, aempty_thr};
            REG_STATUS: reg_rdata <= {18'h00000, cnt, fifo_afull, fifo_aempty,
                                      fifo_full, fifo_empty};
            default:    reg_rdata <= '0;                           // unmapped reads zero
         endcase
      end
   end
endmodule
`default_nettype wire

// File: dprf_chk_assertions.sv
// assertion checker bound to the memory block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module dprf_chk
   import dprf_pkg::*;
(
   input wire logic                          mclk,
   input wire logic                          rst,
   input wire logic                          reg_rd,
   input wire logic [dprf_pkg::REG_AW-1:0]   reg_addr,
   input wire logic [31:0]                   reg_rdata,
   input wire dprf_pkg::dprf_port_req_t      req_a,
   input wire dprf_pkg::dprf_port_rsp_t      rsp_a,
   input wire logic                          fifo_push,
   input wire logic                          fifo_pop,
   input wire logic [dprf_pkg::WORD_W-1:0]   fifo_rdata,
   input wire logic                          fifo_full,
   input wire logic                          fifo_empty,
   input wire logic                          fifo_afull,
   input wire logic                          fifo_aempty,
   input wire logic [dprf_pkg::DATA_W-1:0]   enc_data,
   input wire logic [dprf_pkg::CHK_W-1:0]    enc_check
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("register data outside its read slot");
   a_status_flags: assert property ($past(reg_rd) && $past(reg_addr) == REG_STATUS
      |-> reg_rdata[3:0] == {$past(fifo_afull), $past(fifo_aempty), $past(fifo_full),
      $past(fifo_empty)}) else $error("status flags misreported");
   a_empty_low: assert property (fifo_empty |-> fifo_aempty)
      else $error("empty without nearly empty");
   a_push_full: assert property (fifo_full && !fifo_pop |=> fifo_full)
      else $error("push accepted while full");
   a_pop_empty: assert property (fifo_empty && !fifo_push && !$past(fifo_push)
      |=> fifo_empty && $stable(fifo_rdata))
      else $error("pop accepted while empty");
   a_empty_fall: assert property ($fell(fifo_empty) |-> $past(fifo_push) || $past(fifo_push, 2))
      else $error("queue filled without a push");
   a_enc_parity: assert property (1'b1 |=> ^{$past(enc_data), enc_check} == 1'b0)
      else $error("check word parity wrong");
   a_rsp_hold: assert property (!req_a.en && !$past(req_a.en) && !$past(req_a.en, 2)
      |=> $stable(rsp_a.rdata)) else $error("read data moved while idle");
endmodule
bind dprf_mem dprf_chk chk_u (.mclk, .rst, .reg_rd, .reg_addr, .reg_rdata, .req_a, .rsp_a,
   .fifo_push, .fifo_pop, .fifo_rdata, .fifo_full, .fifo_empty, .fifo_afull, .fifo_aempty,
   .enc_data, .enc_check);
`default_nettype wire

// File: dprf_fabric.sv
// fabric model that feeds the queue strobes and write data
// assumes the bench steers it just after rising edges
`timescale 1ns/1ns
`default_nettype none
module dprf_fabric
   import dprf_pkg::*;
(
   input  wire logic                        mclk,
   input  wire logic                        go_push,
   input  wire logic                        go_pop,
   input  wire logic [dprf_pkg::WORD_W-1:0] word,
   output logic                             fifo_push,
   output logic                             fifo_pop,
   output logic      [dprf_pkg::WORD_W-1:0] fifo_wdata
);
   logic [WORD_W-1:0] held = '0;   // last value on the data lines
   // strobes pass straight through
   assign fifo_push  = go_push;
   assign fifo_pop   = go_pop;
   // idle data lines toggle so a stale word is never taken
   assign fifo_wdata = go_push ? word : ~held;
   always_ff @(posedge mclk)
   begin
      held <= fifo_wdata;
   end
endmodule
`default_nettype wire

// File: tb.sv
// bench for the dual-port memory block, compared with a queue model
// assumes the bound checker and the fabric model beside the design
`timescale 1ns/1ns
`default_nettype none
module tb;
   import dprf_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go_push = 1'b0, go_pop = 1'b0;
   logic fifo_push, fifo_pop, dec_sbit, dec_dbit, fifo_full, fifo_empty, fifo_afull, fifo_aempty;
   logic [7:0] reg_addr = 8'h00, enc_check;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'hF2B64F10, v;
   logic [63:0] enc_data = 64'h0, dec_data;
   logic [71:0] word = 72'h0, dec_word = 72'h0, fifo_wdata, fifo_rdata, x, d, n, e, l, fl;
   dprf_port_req_t req_a = '0, req_b = '0;
   dprf_port_rsp_t rsp_a, rsp_b;
   logic [71:0] q[$];   // queue model, oldest first
   int mismatches = 0, check_count = 0, cycles = 0, thf = 496, the = 16;
   logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
   logic [31:0] rv[7] = '{32'h5, 32'h5, 32'h0, 32'h1F0, 32'h10, 32'h5, 32'h0};
   dprf_mem dut_u (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .req_a, .req_b, .rsp_a, .rsp_b, .casc_in_a(1'b0), .casc_in_b(1'b0), .casc_out_a(),
      .casc_out_b(), .fifo_push, .fifo_wdata, .fifo_pop, .fifo_rdata, .fifo_full, .fifo_empty,
      .fifo_afull, .fifo_aempty, .enc_data, .enc_check, .dec_word, .dec_data, .dec_sbit,
      .dec_dbit);
   dprf_fabric fab_u (.mclk, .go_push, .go_pop, .word, .fifo_push, .fifo_pop, .fifo_wdata);
   always #5 mclk = ~mclk;
   // hang guard
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         close_out();
      end
   end
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // reference check bits
   function automatic logic [7:0] hc(input logic [63:0] dd);
      logic [7:0] c;
      int j;
      c = 8'h00;
      j = 0;
      for (int p = 1; p < 72; p++)
         if ((p & (p - 1)) != 0)
         begin
            for (int i = 0; i < 7; i++)
               c[i] ^= p[i] & dd[j];
            j++;
         end
      c[7] = ^{dd, c[6:0]};
      return c;
   endfunction
   // one register write or read
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dd,
                      output logic [31:0] o);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= dd;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      o = reg_rdata;
   endtask
   // one port access; e one cycle after, l two
   task automatic acc(input bit b, input logic we, input logic [15:0] a, input logic [71:0] dd);
      dprf_port_req_t r;
      r = '{1'b1, we, a, dd};
      @(posedge mclk);
      if (b) req_b <= r;
      else req_a <= r;
      r = '{1'b0, 1'b0, a, ~dd};
      @(posedge mclk);
      if (b) req_b <= r;
      else req_a <= r;
      #1;
      e = b ? rsp_b.rdata : rsp_a.rdata;
      @(posedge mclk);
      #1;
      l = b ? rsp_b.rdata : rsp_a.rdata;
   endtask
   // one queue step judged on the prior state
   task automatic fop(input logic pu, input logic po, input logic fw);
      logic pa, pp;
      logic [71:0] w, ex;
      w = {rnd(), rnd(), 8'h96};
      pa = pu && q.size() < 512;
      pp = po && q.size() > 0;
      @(posedge mclk);
      go_push <= pu;
      go_pop <= po;
      word <= w;
      @(posedge mclk);
      go_push <= 1'b0;
      go_pop <= 1'b0;
      if (fw) @(posedge mclk);
      #1;
      if (pp) ex = q.pop_front();
      if (pa) q.push_back(w);
      if (pp && !fw) chk(fifo_rdata, ex);
      if (fw && q.size() > 0) chk(fifo_rdata, q[0]);
      chk({fifo_full, fifo_empty, fifo_afull, fifo_aempty}, {q.size() == 512,
          q.size() == 0, q.size() >= thf, q.size() <= the});
   endtask
   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         bus(1'b0, ra[i], 32'h0, v);
         chk(v, rv[i]);
      end
      $display("reset values done");
      x = {rnd(), rnd(), 8'hC3};
      d = {rnd(), rnd(), 8'h3C};
      acc(0, 1'b1, 16'h0008, x);
      acc(0, 1'b1, 16'h0006, d);
      for (int p = 0; p < 3; p++)
      begin
         acc(0, 1'b0, 16'h0008, 72'h0);
         chk(l[35:0], x[35:0]);
         bus(1'b1, REG_CFG_A, {26'h0, p[1:0], 4'h5}, v);
         n = {rnd(), rnd(), 8'h5A};
         acc(0, 1'b1, 16'h0006, n);
         chk(l[35:0], p == 0 ? d[35:0] : p == 1 ? n[35:0] : x[35:0]);
         d = n;
      end
      acc(1, 1'b0, 16'h0006, 72'h0);
      chk(l[35:0], d[35:0]);
      bus(1'b1, REG_CFG_A, 32'hD, v);
      acc(0, 1'b0, 16'h0006, 72'h0);
      chk(e[35:0], x[35:0]);
      chk(l[35:0], d[35:0]);
      $display("memory port test done");
      for (int k = 0; k < 15; k++)
      begin
         d = {8'h00, rnd(), rnd()};
         fl = 72'h1 << (rnd() % 72);
         if (k % 3 == 2) fl = fl | {fl[70:0], fl[71]};
         @(posedge mclk);
         enc_data <= d[63:0];
         dec_word <= {hc(d[63:0]), d[63:0]} ^ (k % 3 == 0 ? 72'h0 : fl);
         @(posedge mclk);
         #1;
         chk(enc_check, hc(d[63:0]));
         chk({dec_sbit, dec_dbit}, {k % 3 == 1, k % 3 == 2});
         if (k % 3 < 2) chk(dec_data, d[63:0]);
      end
      $display("check code test done");
      bus(1'b1, REG_AFULL, 32'h100, v);
      bus(1'b1, REG_AEMPTY, 32'h20, v);
      thf = 256;
      the = 32;
      bus(1'b1, REG_MODE, 32'h10, v);
      repeat (513) fop(1'b1, 1'b0, 1'b0);
      fop(1'b1, 1'b1, 1'b0);
      bus(1'b0, REG_STATUS, 32'h0, v);
      chk(v[13:4], q.size());
      repeat (513) fop(1'b0, 1'b1, 1'b0);
      fop(1'b1, 1'b1, 1'b0);
      fop(1'b0, 1'b1, 1'b0);
      $display("standard queue test done");
      bus(1'b1, REG_MODE, 32'h30, v);
      repeat (2) fop(1'b1, 1'b0, 1'b1);
      fop(1'b1, 1'b1, 1'b1);
      repeat (4) fop(1'b0, 1'b1, 1'b1);
      $display("fall-through test done");
      close_out();
   end
endmodule
`default_nettype wire
